/* verilog/i2c_port_select_wake.v */
// Contract
// (RULE1) Each controller owns a 4-bit port field
// (RULE2) Field resets to Fh, attached nowhere
// (RULE3) Field value n selects port n
// (RULE4) Up to ten selectable bus ports
// (RULE5) Software maps each port to one controller
// (RULE6) START on routed bus raises wake event
// (RULE7) Wake handler only clears flag, returns
// (RULE8) Attention needs go through activity event
// (RULE9) System reset returns everything to default
// (RULE10) Bus clock driven from system clock
// (RULE11) Software sets shared pins open-drain
// (RULE12) Enter low power on power unit command
// (RULE13) Unattached controller sees idle, drives nothing
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_defs.vh"

module i2c_port_select_wake #(
    parameter NUM_PORTS = `NUM_PORTS_DEF,
    parameter NUM_CTRL  = `NUM_CTRL_DEF
) (
    input  wire                            sys_clk,
    input  wire                            rstn,
    // Port selection write from each controller's configuration logic
    input  wire [NUM_CTRL-1:0]             sel_wr_en,
    input  wire [NUM_CTRL*`PORT_SEL_W-1:0] sel_wdata,
    output wire [NUM_CTRL*`PORT_SEL_W-1:0] port_sel,
    // Controller core side
    input  wire [NUM_CTRL-1:0]             ctl_sda_pull_low,
    input  wire [NUM_CTRL-1:0]             ctl_scl_pull_low,
    input  wire [NUM_CTRL-1:0]             ctl_activity,
    output reg  [NUM_CTRL-1:0]             ctl_sda_in,
    output reg  [NUM_CTRL-1:0]             ctl_scl_in,
    output reg  [NUM_CTRL-1:0]             bus_start_wake_event,
    output reg  [NUM_CTRL-1:0]             bus_activity_event,
    output reg  [NUM_CTRL-1:0]             bus_busy,
    // Power, clock and reset unit
    input  wire                            low_power_req,
    output reg                             low_power_ack,
    // Open-drain bus pins
    input  wire [NUM_PORTS-1:0]            pin_sda_in,
    input  wire [NUM_PORTS-1:0]            pin_scl_in,
    output wire [NUM_PORTS-1:0]            pin_sda_out,
    output wire [NUM_PORTS-1:0]            pin_scl_out,
    output reg  [NUM_PORTS-1:0]            pin_sda_oe_n,
    output reg  [NUM_PORTS-1:0]            pin_scl_oe_n
);

    localparam [4:0] PORT_LIMIT = NUM_PORTS[4:0];

    // ****************************************************************
    // Port selection storage
    // ****************************************************************
    reg  [NUM_CTRL*`PORT_SEL_W-1:0] port_sel_r;
    reg  [NUM_CTRL*`PORT_SEL_W-1:0] port_sel_nxt;
    reg  [NUM_CTRL-1:0]             sel_changed_r;
    reg  [NUM_CTRL-1:0]             sel_settle_r;
    integer                         k;
    integer                         m;

    always @* begin
        port_sel_nxt = port_sel_r;
        for (k = 0; k < NUM_CTRL; k = k + 1) begin
            if (sel_wr_en[k]) begin
                port_sel_nxt[k*`PORT_SEL_W +: `PORT_SEL_W] =
                    sel_wdata[k*`PORT_SEL_W +: `PORT_SEL_W]; // RULE1
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            port_sel_r    <= {NUM_CTRL{`PORT_SEL_RST}}; // RULE2 RULE9
            sel_changed_r <= {NUM_CTRL{1'b0}};
            sel_settle_r  <= {NUM_CTRL{1'b0}};
        end else begin
            port_sel_r    <= port_sel_nxt;
            sel_changed_r <= sel_wr_en;
            // The old route's level lingers one more cycle in the detector history
            sel_settle_r  <= sel_changed_r;
        end
    end

    assign port_sel = port_sel_r;

    // ****************************************************************
    // Low power handshake
    // ****************************************************************
    // Drives are released while asleep; start detection keeps running so a
    // master on the bus can still wake the chip
    always @(posedge sys_clk) begin
        if (!rstn) begin
            low_power_ack <= 1'b0;
        end else begin
            low_power_ack <= low_power_req; // RULE12
        end
    end

    // ****************************************************************
    // Pin input synchronisers
    // ****************************************************************
    reg [NUM_PORTS-1:0] sda_s1_r;
    reg [NUM_PORTS-1:0] sda_s2_r;
    reg [NUM_PORTS-1:0] scl_s1_r;
    reg [NUM_PORTS-1:0] scl_s2_r;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            sda_s1_r <= {NUM_PORTS{`LINE_IDLE}};
            sda_s2_r <= {NUM_PORTS{`LINE_IDLE}};
            scl_s1_r <= {NUM_PORTS{`LINE_IDLE}};
            scl_s2_r <= {NUM_PORTS{`LINE_IDLE}};
        end else begin
            sda_s1_r <= pin_sda_in;
            sda_s2_r <= sda_s1_r;
            scl_s1_r <= pin_scl_in;
            scl_s2_r <= scl_s1_r;
        end
    end

    // ****************************************************************
    // Per-controller routing of received lines and events
    // ****************************************************************
    wire [NUM_CTRL-1:0] attached;
    wire [NUM_CTRL-1:0] start_seen;
    wire [NUM_CTRL-1:0] stop_seen;

    genvar c;
    generate
        for (c = 0; c < NUM_CTRL; c = c + 1) begin : g_ctrl
            wire [`PORT_SEL_W-1:0] sel_c;
            assign sel_c = port_sel_r[c*`PORT_SEL_W +: `PORT_SEL_W];
            // Fh and any code beyond the last port leave the controller detached
            assign attached[c] = (sel_c != `PORT_SEL_NONE) &&
                                 ({1'b0, sel_c} < PORT_LIMIT); // RULE2 RULE4

            always @(posedge sys_clk) begin
                if (!rstn) begin
                    ctl_sda_in[c] <= `LINE_IDLE;
                    ctl_scl_in[c] <= `LINE_IDLE;
                end else if (attached[c]) begin
                    ctl_sda_in[c] <= sda_s2_r[sel_c]; // RULE3
                    ctl_scl_in[c] <= scl_s2_r[sel_c]; // RULE3
                end else begin
                    ctl_sda_in[c] <= `LINE_IDLE; // RULE13
                    ctl_scl_in[c] <= `LINE_IDLE; // RULE13
                end
            end

            start_detect u_start_detect (
                .sys_clk     (sys_clk),
                .rstn        (rstn),
                .hold        (sel_changed_r[c] | sel_settle_r[c]),
                .sda         (ctl_sda_in[c]),
                .scl         (ctl_scl_in[c]),
                .start_pulse (start_seen[c]),
                .stop_pulse  (stop_seen[c])
            );
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (!rstn) begin
            bus_start_wake_event <= {NUM_CTRL{1'b0}};
            bus_activity_event   <= {NUM_CTRL{1'b0}};
            bus_busy             <= {NUM_CTRL{1'b0}};
        end else begin
            bus_start_wake_event <= start_seen & attached; // RULE6
            // Attention requests never share the wake line
            bus_activity_event   <= ctl_activity; // RULE8
            for (m = 0; m < NUM_CTRL; m = m + 1) begin
                if (!attached[m]) begin
                    bus_busy[m] <= 1'b0;
                end else if (start_seen[m]) begin
                    bus_busy[m] <= 1'b1;
                end else if (stop_seen[m]) begin
                    bus_busy[m] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Per-port open-drain drive
    // ****************************************************************
    // Two controllers on one port simply wire-AND; software must avoid it
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            localparam integer           PNUM = p;
            localparam [`PORT_SEL_W-1:0] PIDX = PNUM[`PORT_SEL_W-1:0];
            reg sda_pull;
            reg scl_pull;
            integer j;

            always @* begin
                sda_pull = 1'b0;
                scl_pull = 1'b0;
                for (j = 0; j < NUM_CTRL; j = j + 1) begin
                    if (port_sel_r[j*`PORT_SEL_W +: `PORT_SEL_W] == PIDX) begin // RULE3 RULE5
                        sda_pull = sda_pull | ctl_sda_pull_low[j];
                        scl_pull = scl_pull | ctl_scl_pull_low[j]; // RULE10
                    end
                end
            end

            always @(posedge sys_clk) begin
                if (!rstn) begin
                    pin_sda_oe_n[p] <= 1'b1;
                    pin_scl_oe_n[p] <= 1'b1;
                end else begin
                    // Unselected ports and sleep leave the pin released
                    pin_sda_oe_n[p] <= !(sda_pull && !low_power_ack); // RULE13 RULE12
                    pin_scl_oe_n[p] <= !(scl_pull && !low_power_ack); // RULE10 RULE13
                end
            end
        end
    endgenerate

    // Open-drain: the driven level is always low, enable decides
    assign pin_sda_out = {NUM_PORTS{`PIN_OUT_LOW}};
    assign pin_scl_out = {NUM_PORTS{`PIN_OUT_LOW}};

endmodule // i2c_port_select_wake

`default_nettype wire

/* verilog/i2c_port_defs.vh */
`ifndef I2C_PORT_DEFS_VH
`define I2C_PORT_DEFS_VH

// ****************************************************************
// Port selection field
// ****************************************************************
`define PORT_SEL_W        4
`define PORT_SEL_RST      4'hF
`define PORT_SEL_NONE     4'hF

// ****************************************************************
// Sizing defaults
// ****************************************************************
`define NUM_PORTS_DEF     10
`define NUM_CTRL_DEF      2

// ****************************************************************
// Idle line level and open-drain output value
// ****************************************************************
`define LINE_IDLE         1'b1
`define PIN_OUT_LOW       1'b0

`endif

/* verilog/start_detect.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Start and stop condition detector for one routed bus
// ****************************************************************
module start_detect (
    input  wire sys_clk,
    input  wire rstn,
    input  wire hold,
    input  wire sda,
    input  wire scl,
    output reg  start_pulse,
    output reg  stop_pulse
);

    reg sda_prev_r;
    reg scl_prev_r;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            sda_prev_r  <= 1'b1;
            scl_prev_r  <= 1'b1;
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
        end else begin
            sda_prev_r  <= sda;
            scl_prev_r  <= scl;
            // Hold masks the two cycles after a route change, covering the one where the old and new
            // bus levels would otherwise look like an edge
            start_pulse <= !hold && sda_prev_r && !sda && scl_prev_r && scl; // RULE6
            stop_pulse  <= !hold && !sda_prev_r && sda && scl_prev_r && scl;
        end
    end

endmodule // start_detect

`default_nettype wire

/* tb/bus_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-end agent on the open-drain ports
// ****************************************
module bus_far_end #(
    parameter int NP = 10
) (
    input  wire logic          sys_clk,
    input  wire logic [NP-1:0] sda_oe_n,
    input  wire logic [NP-1:0] scl_oe_n,
    output var  logic [NP-1:0] sda,
    output var  logic [NP-1:0] scl
);
    logic [NP-1:0] sda_r = '1;
    logic [NP-1:0] scl_r = '1;
    // Pull-ups: a released line reads high, never a stale level
    always_comb sda = sda_r & sda_oe_n;
    always_comb scl = scl_r & scl_oe_n;
    // Clock stands still outside the frame
    task automatic frame(input int p);
        repeat (3) @(negedge sys_clk);
        sda_r[p] = 1'h0;
        repeat (8) @(negedge sys_clk);
        scl_r[p] = 1'h0;
        repeat (8) @(negedge sys_clk);
        scl_r[p] = 1'h1;
        repeat (8) @(negedge sys_clk);
        sda_r[p] = 1'h1;
    endtask
endmodule // bus_far_end
`default_nettype wire

/* tb/port_wake_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module port_wake_chk #(
    parameter NUM_PORTS = 10,
    parameter NUM_CTRL  = 2
) (
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    input wire logic [NUM_CTRL-1:0]   sel_wr_en,
    input wire logic [4*NUM_CTRL-1:0] sel_wdata,
    input wire logic [4*NUM_CTRL-1:0] port_sel,
    input wire logic [NUM_CTRL-1:0]   ctl_sda_pull_low,
    input wire logic [NUM_CTRL-1:0]   ctl_activity,
    input wire logic [NUM_CTRL-1:0]   ctl_sda_in,
    input wire logic [NUM_CTRL-1:0]   ctl_scl_in,
    input wire logic [NUM_CTRL-1:0]   bus_start_wake_event,
    input wire logic [NUM_CTRL-1:0]   bus_activity_event,
    input wire logic                  low_power_req,
    input wire logic                  low_power_ack,
    input wire logic [NUM_PORTS-1:0]  pin_sda_in,
    input wire logic [NUM_PORTS-1:0]  pin_sda_oe_n,
    input wire logic [NUM_PORTS-1:0]  pin_scl_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence start_seq;
        $fell(ctl_sda_in[0]) && ctl_scl_in[0] && $past(ctl_scl_in[0]) && !$past(sel_wr_en[0], 2);
    endsequence
    sequence held_on_two;
        port_sel[3:0] == 4'h2 && $past(port_sel[3:0], 3) == 4'h2;
    endsequence
    chk_sel_update: assert property (sel_wr_en[0] |=> port_sel[3:0] == $past(sel_wdata[3:0]))
        else $error("port field not loaded");
    chk_reset_default: assert property ($rose(rstn) |-> port_sel == '1 && bus_start_wake_event == '0)
        else $error("not at default after reset");
    chk_route_in: assert property (held_on_two |-> ctl_sda_in[0] == $past(pin_sda_in[2], 3))
        else $error("data line not routed from port");
    chk_detach_idle: assert property (port_sel[3:0] == 4'hF && $past(port_sel[3:0], 3) == 4'hF |-> ctl_sda_in[0] && ctl_scl_in[0])
        else $error("detached controller not idle");
    chk_detach_nodrive: assert property (port_sel == '1 && $past(port_sel) == '1 |-> &pin_sda_oe_n && &pin_scl_oe_n)
        else $error("detached controller drives a port");
    chk_drive_out: assert property (ctl_sda_pull_low[0] && port_sel[3:0] < NUM_PORTS && !sel_wr_en[0] && !low_power_req && !low_power_ack |=> pin_sda_oe_n[$past(port_sel[3:0])] == 1'h0)
        else $error("selected port not driven");
    chk_wake_start: assert property (start_seq |-> ##[1:3] bus_start_wake_event[0])
        else $error("start did not wake");
    chk_wake_cause: assert property (bus_start_wake_event[0] |-> $past(ctl_sda_in[0], 3) && !$past(ctl_sda_in[0], 2) && $past(ctl_scl_in[0], 3) && $past(ctl_scl_in[0], 2))
        else $error("wake without start");
    chk_activity_pass: assert property (bus_activity_event == $past(ctl_activity))
        else $error("activity event mismatch");
    chk_power_ack: assert property (low_power_ack == $past(low_power_req))
        else $error("low power ack mismatch");
    chk_power_quiet: assert property (low_power_ack && $past(low_power_ack) |-> &pin_sda_oe_n && &pin_scl_oe_n)
        else $error("drive while in low power");
endmodule // port_wake_chk
bind i2c_port_select_wake port_wake_chk #(.NUM_PORTS(NUM_PORTS), .NUM_CTRL(NUM_CTRL)) u_chk (
    .sys_clk, .rstn, .sel_wr_en, .sel_wdata, .port_sel, .ctl_sda_pull_low, .ctl_activity,
    .ctl_sda_in, .ctl_scl_in, .bus_start_wake_event, .bus_activity_event, .low_power_req,
    .low_power_ack, .pin_sda_in, .pin_sda_oe_n, .pin_scl_oe_n);
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic            sys_clk         = 1'h0;
    logic            rstn            = 1'h0;
    logic            low_power_req   = 1'h0;
    logic [1:0]      sel_wr_en       = 2'h0;
    logic [7:0]      sel_wdata       = 8'h00;
    logic [1:0]      sda_pull        = 2'h0;
    logic [1:0]      scl_pull        = 2'h0;
    logic [1:0]      activity        = 2'h0;
    wire logic [7:0] port_sel;
    wire logic [1:0] ctl_sda_in, ctl_scl_in, wake, act_ev, busy;
    wire logic       ack;
    wire logic [9:0] sda, scl, sda_oe_n, scl_oe_n, sda_out, scl_out;
    int              mismatches      = 0;
    int              samples_checked = 0;
    i2c_port_select_wake #(.NUM_PORTS(10), .NUM_CTRL(2)) DUT (
        .sys_clk, .rstn, .sel_wr_en, .sel_wdata, .port_sel, .ctl_sda_pull_low(sda_pull),
        .ctl_scl_pull_low(scl_pull), .ctl_activity(activity), .ctl_sda_in, .ctl_scl_in,
        .bus_start_wake_event(wake), .bus_activity_event(act_ev), .bus_busy(busy),
        .low_power_req, .low_power_ack(ack), .pin_sda_in(sda), .pin_scl_in(scl),
        .pin_sda_out(sda_out), .pin_scl_out(scl_out), .pin_sda_oe_n(sda_oe_n),
        .pin_scl_oe_n(scl_oe_n));
    bus_far_end #(.NP(10)) far (.sys_clk, .sda_oe_n, .scl_oe_n, .sda, .scl);
    initial forever #2 sys_clk = ~sys_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input int c, input logic [3:0] v);
        sel_wr_en[c] = 1'h1;
        sel_wdata[4*c +: 4] = v;
        cyc(1);
        sel_wr_en[c] = 1'h0;
        cyc(1);
    endtask
    task automatic frame_wake(input int p, input logic [1:0] exp);
        logic [1:0] seen;
        logic [1:0] busy_seen;
        seen = 2'h0;
        busy_seen = 2'h0;
        fork
            far.frame(p);
            repeat (40) @(posedge sys_clk) #1 begin
                seen = seen | wake;
                busy_seen = busy_seen | busy;
            end
        join
        cyc(1);
        check(seen, exp);
        check(busy_seen, exp);
        check({wake, busy}, 4'h0);
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        print_verdict;
    end
    initial begin
        logic [9:0] e;
        cyc(4);
        rstn = 1'h1;
        cyc(1);
        check(port_sel, 8'hFF);
        check({ctl_sda_in, ctl_scl_in, wake, act_ev}, 8'hF0);
        check({sda_oe_n, scl_oe_n}, 20'hFFFFF);
        check(busy, 2'h0);
        check({sda_out, scl_out}, 20'h00000);
        $display("reset test done");
        for (int p = 0; p < 16; p++) begin
            e = 10'h3FF;
            if (p < 10) e[p] = 1'h0;
            wr(0, p[3:0]);
            sda_pull[0] = 1'h1;
            cyc(5);
            check(port_sel[3:0], p[3:0]);
            check(sda_oe_n, e);
            check(ctl_sda_in[0], &e);
            sda_pull[0] = 1'h0;
            cyc(5);
        end
        $display("routing test done");
        wr(0, 4'h2);
        wr(1, 4'h5);
        scl_pull = 2'h3;
        cyc(2);
        check(port_sel, 8'h52);
        check(scl_oe_n, 10'h3DB);
        scl_pull = 2'h0;
        cyc(5);
        frame_wake(2, 2'h1);
        frame_wake(5, 2'h2);
        frame_wake(7, 2'h0);
        $display("wake test done");
        activity = 2'h2;
        cyc(1);
        check({act_ev, wake}, 4'h8);
        activity = 2'h0;
        cyc(1);
        check(act_ev, 2'h0);
        $display("activity test done");
        low_power_req = 1'h1;
        cyc(2);
        sda_pull = 2'h3;
        cyc(2);
        check({ack, sda_oe_n}, 11'h7FF);
        frame_wake(5, 2'h2);
        low_power_req = 1'h0;
        sda_pull = 2'h0;
        cyc(2);
        $display("low power test done");
        rstn = 1'h0;
        cyc(4);
        rstn = 1'h1;
        cyc(1);
        check({port_sel, ack}, 9'h1FE);
        $display("second reset test done");
        print_verdict;
    end
endmodule // tb
`default_nettype wire
